// *** hdl/lfs_pkg.sv ***
// Package for the line feed state control block
`default_nettype none
package lfs_pkg;

  // Feed state codes, one per 3-bit value
  typedef enum logic [2:0] {
    LFS_OPEN     = 3'h0,
    LFS_FWD_ACT  = 3'h1,
    LFS_FWD_OHT  = 3'h2,
    LFS_TIP_OPEN = 3'h3,
    LFS_RINGING  = 3'h4,
    LFS_REV_ACT  = 3'h5,
    LFS_REV_OHT  = 3'h6,
    LFS_RING_OPN = 3'h7
  } lfs_state_t;

  // Register offsets (word index on the register port)
  localparam logic [3:0] LFS_ADDR_FEED_STATE = 4'h0;
  localparam logic [3:0] LFS_ADDR_CUR_LIMIT = 4'h1;
  localparam logic [3:0] LFS_ADDR_OC_TARGET = 4'h2;
  localparam logic [3:0] LFS_ADDR_CM_OFFSET = 4'h3;
  localparam logic [3:0] LFS_ADDR_BOOST_STEP = 4'h4;
  localparam logic [3:0] LFS_ADDR_BOOST_LTH = 4'h5;
  localparam logic [3:0] LFS_ADDR_BOOST_HTH = 4'h6;
  localparam logic [3:0] LFS_ADDR_BAT_HEAD = 4'h7;
  localparam logic [3:0] LFS_ADDR_RING_HEAD = 4'h8;
  localparam logic [3:0] LFS_ADDR_TRACK = 4'h9;

  // Field positions in feed_state_control
  localparam int LFS_CODE_LSB = 0;
  localparam int LFS_MIRROR_LSB = 4;
  localparam int LFS_FAULT_BIT = 7;

  // Reset values
  localparam logic [2:0] LFS_CODE_RST = 3'h0;
  localparam logic [4:0] LFS_CUR_LIMIT_RST = 5'h00;
  localparam logic [14:0] LFS_OC_TARGET_RST = 15'h0000;
  // 3 V common-mode headroom in parameter units
  localparam logic [14:0] LFS_CM_OFFSET_RST = 15'h0268;
  localparam logic [14:0] LFS_HEAD_RST = 15'h0000;
  localparam logic [15:0] LFS_THD_RST = 16'h0000;

  // Line driver control word
  typedef struct packed {
    logic tip_drive_off;   // Tip lead high impedance
    logic ring_drive_off;  // Ring lead high impedance
    logic reverse;         // Reverse feed polarity
    logic ringing;         // Ringing waveform on loop
    logic audio_on;        // Audio paths powered
    logic low_power;       // On-hook standby power saving
    logic onhook_tx;       // On-hook transmission enabled
  } lfs_drive_t;

endpackage : lfs_pkg
`default_nettype wire

// *** hdl/lfs_line_feed_state_control.sv ***
// Line feed state control: state decode, fault fall back, feed parameters
//
// Overview of operation
// - Three-bit feed state code decodes into eight distinct line states.
// - After reset, with nothing loaded, the line sits in the open state.
// - Driver excess-power fault forces open state without any software write.
// - Open state puts both driver outputs in high impedance.
// - Code 001 forward feed, audio off until off-hook, low power on-hook.
// - Code 101 reverse feed, audio off until off-hook, low power on-hook.
// - Code 010 forward polarity on-hook data transmission.
// - Code 110 reverse polarity on-hook data transmission.
// - Code 011 tip driver high impedance, ring feed active.
// - Code 111 ring driver high impedance, tip feed active.
// - Code 100 drives the ringing waveform onto the loop.
// - Loop current limit is a software five-bit field, 18 to 45 mA.
// - Battery above target plus both offsets: tracked level equals programmed target.
// - Battery below that sum: tracked level falls with battery.
// - Common-mode offset defaults to 3 V.
`default_nettype none
module lfs_line_feed_state_control
  import lfs_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  // Line side status
  input wire logic i_power_fault,
  input wire logic i_offhook,
  input wire logic [15:0] i_battery_level,
  // Line driver controls
  output lfs_pkg::lfs_drive_t o_drive,
  output logic [4:0] o_loop_current_limit,
  output logic [15:0] o_tracked_open_circuit_level
);
  import lfs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic fault_meta;
  logic fault_sync;
  logic hook_meta;
  logic hook_sync;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
      hook_meta <= 1'b0;
      hook_sync <= 1'b0;
    end
    else
    begin
      fault_meta <= i_power_fault;
      fault_sync <= fault_meta;
      hook_meta <= i_offhook;
      hook_sync <= hook_meta;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic [2:0] feed_state_code;
  logic [4:0] loop_current_limit;
  logic [14:0] open_circuit_target;
  logic [14:0] common_mode_offset;
  logic [14:0] offhook_boost_step;
  logic [15:0] boost_low_threshold;
  logic [15:0] boost_high_threshold;
  logic [14:0] battery_headroom_offset;
  logic [14:0] ringing_headroom_offset;
  logic code_wr;

  assign code_wr = i_reg_wr && (i_reg_addr == LFS_ADDR_FEED_STATE);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      feed_state_code <= LFS_CODE_RST;
    else if (code_wr)
      feed_state_code <= i_reg_wdata[LFS_CODE_LSB +: 3];
  end

  // ----------------------------------------------------------------
  // Feed parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      loop_current_limit <= LFS_CUR_LIMIT_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_CUR_LIMIT))
      loop_current_limit <= i_reg_wdata[4:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      open_circuit_target <= LFS_OC_TARGET_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_OC_TARGET))
      open_circuit_target <= i_reg_wdata[14:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      common_mode_offset <= LFS_CM_OFFSET_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_CM_OFFSET))
      common_mode_offset <= i_reg_wdata[14:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      battery_headroom_offset <= LFS_HEAD_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_BAT_HEAD))
      battery_headroom_offset <= i_reg_wdata[14:0];
  end

  // ----------------------------------------------------------------
  // Stored-only parameters
  // ----------------------------------------------------------------
  // Kept for software; only the register read-back uses them
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      offhook_boost_step <= LFS_HEAD_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_BOOST_STEP))
      offhook_boost_step <= i_reg_wdata[14:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      boost_low_threshold <= LFS_THD_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_BOOST_LTH))
      boost_low_threshold <= i_reg_wdata[15:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      boost_high_threshold <= LFS_THD_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_BOOST_HTH))
      boost_high_threshold <= i_reg_wdata[15:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ringing_headroom_offset <= LFS_HEAD_RST;
    else if (i_reg_wr && (i_reg_addr == LFS_ADDR_RING_HEAD))
      ringing_headroom_offset <= i_reg_wdata[14:0];
  end

  // ----------------------------------------------------------------
  // Power fault latch
  // ----------------------------------------------------------------
  // Held until software writes a new code; a fault in that cycle wins
  logic fault_latched;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      fault_latched <= 1'b0;
    else if (fault_sync)
      fault_latched <= 1'b1;
    else if (code_wr)
      fault_latched <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Applied state
  // ----------------------------------------------------------------
  lfs_state_t applied;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      applied <= LFS_OPEN;
    else if (fault_sync || fault_latched)
      applied <= LFS_OPEN;
    else
      applied <= lfs_state_t'(feed_state_code);
  end

  // ----------------------------------------------------------------
  // Driver control decode
  // ----------------------------------------------------------------
  lfs_drive_t next_drive;

  always_comb
  begin
    next_drive = '0;
    case (applied)
      LFS_OPEN:
      begin
        next_drive.tip_drive_off = 1'b1;
        next_drive.ring_drive_off = 1'b1;
      end
      LFS_FWD_ACT:
      begin
        next_drive.audio_on = hook_sync;
        next_drive.low_power = !hook_sync;
      end
      LFS_FWD_OHT:
      begin
        next_drive.audio_on = 1'b1;
        next_drive.onhook_tx = 1'b1;
      end
      LFS_TIP_OPEN:
        next_drive.tip_drive_off = 1'b1;
      LFS_RINGING:
        next_drive.ringing = 1'b1;
      LFS_REV_ACT:
      begin
        next_drive.reverse = 1'b1;
        next_drive.audio_on = hook_sync;
        next_drive.low_power = !hook_sync;
      end
      LFS_REV_OHT:
      begin
        next_drive.reverse = 1'b1;
        next_drive.audio_on = 1'b1;
        next_drive.onhook_tx = 1'b1;
      end
      LFS_RING_OPN:
        next_drive.ring_drive_off = 1'b1;
      default:
      begin
        next_drive.tip_drive_off = 1'b1;
        next_drive.ring_drive_off = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_drive <= '0;
      o_drive.tip_drive_off <= 1'b1;
      o_drive.ring_drive_off <= 1'b1;
    end
    else
      o_drive <= next_drive;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_loop_current_limit <= LFS_CUR_LIMIT_RST;
    else
      o_loop_current_limit <= loop_current_limit;
  end

  // ----------------------------------------------------------------
  // Open-circuit level tracking against battery
  // ----------------------------------------------------------------
  logic [17:0] headroom_sum;
  logic [17:0] offsets;
  logic [17:0] next_track_wide;
  logic [15:0] next_track;

  always_comb
  begin
    offsets = 18'(common_mode_offset) + 18'(battery_headroom_offset);
    headroom_sum = 18'(open_circuit_target) + offsets;
    if (18'(i_battery_level) > headroom_sum)
      next_track_wide = 18'(open_circuit_target);
    else if (18'(i_battery_level) > offsets)
      next_track_wide = 18'(i_battery_level) - offsets;
    else
      next_track_wide = '0;
    next_track = next_track_wide[15:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_tracked_open_circuit_level <= '0;
    else
      o_tracked_open_circuit_level <= next_track;
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  logic [7:0] feed_state_control;

  always_comb
  begin
    feed_state_control = '0;
    feed_state_control[LFS_CODE_LSB +: 3] = feed_state_code;
    feed_state_control[LFS_MIRROR_LSB +: 3] = applied;
    feed_state_control[LFS_FAULT_BIT] = fault_latched;
    next_rdata = '0;
    if (i_reg_addr == LFS_ADDR_FEED_STATE)
      next_rdata = DATA_W'(feed_state_control);
    else if (i_reg_addr == LFS_ADDR_CUR_LIMIT)
      next_rdata = DATA_W'(loop_current_limit);
    else if (i_reg_addr == LFS_ADDR_OC_TARGET)
      next_rdata = DATA_W'(open_circuit_target);
    else if (i_reg_addr == LFS_ADDR_CM_OFFSET)
      next_rdata = DATA_W'(common_mode_offset);
    else if (i_reg_addr == LFS_ADDR_BOOST_STEP)
      next_rdata = DATA_W'(offhook_boost_step);
    else if (i_reg_addr == LFS_ADDR_BOOST_LTH)
      next_rdata = DATA_W'(boost_low_threshold);
    else if (i_reg_addr == LFS_ADDR_BOOST_HTH)
      next_rdata = DATA_W'(boost_high_threshold);
    else if (i_reg_addr == LFS_ADDR_BAT_HEAD)
      next_rdata = DATA_W'(battery_headroom_offset);
    else if (i_reg_addr == LFS_ADDR_RING_HEAD)
      next_rdata = DATA_W'(ringing_headroom_offset);
    else if (i_reg_addr == LFS_ADDR_TRACK)
      next_rdata = DATA_W'(o_tracked_open_circuit_level);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_reg_rdata <= '0;
    else if (i_reg_rd)
      o_reg_rdata <= next_rdata;
  end

endmodule : lfs_line_feed_state_control
`default_nettype wire

// *** bench/lfs_properties.sv ***
// Port checker for the line feed state control block
`default_nettype none
module lfs_properties
  import lfs_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic [DATA_W-1:0] o_reg_rdata,
  input wire logic i_power_fault,
  input wire lfs_pkg::lfs_drive_t o_drive,
  input wire logic [4:0] o_loop_current_limit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic is_open = o_drive.tip_drive_off && o_drive.ring_drive_off;
  sequence s_tip_wr;
    !i_power_fault [*3] ##0 (i_reg_wr && i_reg_addr == LFS_ADDR_FEED_STATE && i_reg_wdata[2:0] == 3'h3);
  endsequence
  sequence s_quiet;
    (!i_reg_wr && !i_power_fault) [*2];
  endsequence
  a_reset_open: assert property ($rose(i_arst_n) |-> is_open)
    else $error("drive not open after reset");
  a_open_quiet: assert property (is_open |-> !(o_drive.ringing || o_drive.audio_on || o_drive.onhook_tx))
    else $error("open line still driven");
  a_fault_reach: assert property ($rose(i_power_fault) |-> ##[1:5] is_open)
    else $error("fault did not open line");
  a_fault_hold: assert property (i_power_fault [*6] |-> is_open)
    else $error("line fed during fault");
  a_tip_apply: assert property (s_tip_wr ##1 s_quiet |=> o_drive.tip_drive_off && !o_drive.ring_drive_off)
    else $error("tip open not applied");
  a_mirror_fault: assert property (i_power_fault [*6] ##0 (i_reg_rd && i_reg_addr == 4'h0) |=> o_reg_rdata[7:4] == 4'h8)
    else $error("mirror not open on fault");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > LFS_ADDR_TRACK |=> o_reg_rdata == '0)
    else $error("unmapped read not zero");
  a_loop_current_limit_hold: assert property (!i_reg_wr [*3] |-> $stable(o_loop_current_limit))
    else $error("current limit moved");
endmodule // lfs_properties
bind lfs_line_feed_state_control lfs_properties #(.DATA_W(DATA_W)) i_lfs_properties (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_power_fault(i_power_fault),
  .o_drive(o_drive), .o_loop_current_limit(o_loop_current_limit));
`default_nettype wire

// *** bench/lfs_driver_model.sv ***
// Behavioural model of the line driver and subscriber loop
`default_nettype none
module lfs_driver_model
  import lfs_pkg::*;
(
  input wire logic i_clk,
  input wire lfs_pkg::lfs_drive_t i_drive,
  input wire logic i_overload,
  input wire logic i_lift,
  output var logic o_power_fault = 1'b0,
  output logic o_offhook
);
  timeunit 1ns;
  timeprecision 1ns;
  // Overload shows as a fault one cycle later
  always @(posedge i_clk) o_power_fault <= i_overload;
  // Loop current only flows on a fed line
  assign o_offhook = i_lift && !(i_drive.tip_drive_off && i_drive.ring_drive_off);
endmodule // lfs_driver_model
`default_nettype wire

// *** bench/line_feed_state_control_bench.sv ***
// Self-checking bench for the line feed state control block
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module line_feed_state_control_bench;
  import lfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] i_battery_level = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic [15:0] o_tracked_open_circuit_level;
  logic [4:0] o_loop_current_limit;
  logic i_power_fault;
  logic i_offhook;
  logic overload = 1'b0;
  logic lift = 1'b0;
  lfs_drive_t o_drive;
  int num_errors = 0;
  int n_checks = 0;
  logic [15:0] rd;
  logic [15:0] msk [1:8] = '{16'h001f, 16'h7fff, 16'h7fff, 16'h7fff, 16'hffff, 16'hffff, 16'h7fff, 16'h7fff};
  logic [15:0] bat [4] = '{16'h1000, 16'h0100, 16'h0130, 16'h0020};
  logic [15:0] trk [4] = '{16'h0100, 16'h00d0, 16'h0100, 16'h0000};
  localparam lfs_drive_t OPEN = 7'h60;

  always #25 i_clk = ~i_clk;

  lfs_line_feed_state_control #(.DATA_W(16)) i_lfs_line_feed_state_control (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_power_fault(i_power_fault), .i_offhook(i_offhook),
    .i_battery_level(i_battery_level), .o_drive(o_drive), .o_loop_current_limit(o_loop_current_limit),
    .o_tracked_open_circuit_level(o_tracked_open_circuit_level));
  lfs_driver_model i_lfs_driver_model (.i_clk(i_clk), .i_drive(o_drive), .i_overload(overload), .i_lift(lift),
    .o_power_fault(i_power_fault), .o_offhook(i_offhook));

  task automatic final_report();
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 rd = o_reg_rdata;
  endtask
  // Expected driver word for a state code and hook state
  function automatic lfs_drive_t exp_drive(input logic [2:0] c, input logic h);
    lfs_drive_t d;
    d = '0;
    d.tip_drive_off = c == 3'h0 || c == 3'h3;
    d.ring_drive_off = c == 3'h0 || c == 3'h7;
    d.reverse = c == 3'h5 || c == 3'h6;
    d.ringing = c == 3'h4;
    d.audio_on = (c[1:0] == 2'h1 && h) || c[1:0] == 2'h2;
    d.low_power = c[1:0] == 2'h1 && !h;
    d.onhook_tx = c[1:0] == 2'h2;
    return d;
  endfunction

  task automatic t_reset();
    for (int a = 0; a < 10; a++)
    begin
      rdr(a[3:0]);
      `CHK("reset reg", (a == 3) ? 16'(LFS_CM_OFFSET_RST) : 16'h0000, rd)
    end
    rdr(4'hc);
    `CHK("unmapped", 16'h0000, rd)
    `CHK("reset drive", OPEN, o_drive)
  endtask
  task automatic t_decode();
    for (int c = 0; c < 8; c++)
    begin
      wr(LFS_ADDR_FEED_STATE, 16'(c));
      cyc(3);
      `CHK("drive", exp_drive(c[2:0], 1'b0), o_drive)
      rdr(LFS_ADDR_FEED_STATE);
      `CHK("mirror", {9'h000, c[2:0], 1'b0, c[2:0]}, rd)
    end
    lift <= 1'b1;
    for (int c = 1; c < 8; c += 4)
    begin
      wr(LFS_ADDR_FEED_STATE, 16'(c));
      cyc(8);
      `CHK("lifted drive", exp_drive(c[2:0], 1'b1), o_drive)
    end
    lift <= 1'b0;
  endtask
  task automatic t_fault();
    int k;
    wr(LFS_ADDR_FEED_STATE, 16'h0001);
    overload <= 1'b1;
    for (k = 0; k < 8 && o_drive !== OPEN; k++)
      cyc(1);
    if (k == 8)
    begin
      num_errors++;
      $display("unexpected fault wait: expected %h seen %h", OPEN, o_drive);
      final_report();
    end
    cyc(2);
    rdr(LFS_ADDR_FEED_STATE);
    `CHK("fault mirror", 16'h0081, rd)
    wr(LFS_ADDR_FEED_STATE, 16'h0002);
    cyc(3);
    `CHK("fault wins", OPEN, o_drive)
    overload <= 1'b0;
    cyc(6);
    `CHK("fault latched", OPEN, o_drive)
    wr(LFS_ADDR_FEED_STATE, 16'h0002);
    cyc(3);
    `CHK("after clear", exp_drive(3'h2, 1'b0), o_drive)
  endtask
  task automatic t_regs();
    for (int a = 1; a < 9; a++)
    begin
      wr(a[3:0], 16'hffff);
      rdr(a[3:0]);
      `CHK("reg width", msk[a], rd)
    end
    `CHK("loop_current_limit out", 5'h1f, o_loop_current_limit)
    wr(LFS_ADDR_FEED_STATE, 16'hfff8);
    cyc(2);
    rdr(LFS_ADDR_FEED_STATE);
    `CHK("feed ro bits", 16'h0000, rd)
  endtask
  task automatic t_track();
    wr(LFS_ADDR_OC_TARGET, 16'h0100);
    wr(LFS_ADDR_CM_OFFSET, 16'h0010);
    wr(LFS_ADDR_BAT_HEAD, 16'h0020);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_clk);
      i_battery_level <= bat[i];
      cyc(3);
      `CHK("track", trk[i], o_tracked_open_circuit_level)
    end
    wr(LFS_ADDR_TRACK, 16'h1234);
    rdr(LFS_ADDR_TRACK);
    `CHK("track ro", 16'h0000, rd)
  endtask

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_decode();
    t_fault();
    t_regs();
    t_track();
    final_report();
  end
endmodule // line_feed_state_control_bench
`default_nettype wire
